// ---- fcd_card.sv ----
module fcd_card (
  // Clock.
  input wire logic clock,
  // Response byte stream towards the decoder.
  output fcd_pkg::fcd_byte_t rx
);
  timeunit 1ns;
  timeprecision 1ps;
  import fcd_pkg::*;
  logic send_valid = 1'b0;
  logic send_last = 1'b0;
  logic [7:0] send_data = 8'h00;
  logic [7:0] idle_r = 8'h3C;
  logic [7:0] q[$];

  // ----
  // Idle line pattern.
  // ----
  // Data changes every cycle between bytes so a stale value never passes.
  always @(posedge clock) begin
    idle_r <= idle_r + 8'h5B;
  end
  assign rx = {send_valid, send_last, send_valid ? send_data : idle_r};

  task automatic push(input logic [7:0] b[$]);
    q = {q, b};
  endtask

  task automatic add_desc(input logic [7:0] fd, input logic [7:0] coding);
    if (fd[2:0] == 3'h2 || fd[2:0] == 3'h6) begin
      push({8'h82, 8'h05, fd, coding,
        8'h00, 8'h1C, 8'h07});
    end else begin
      push({8'h82, 8'h02, fd, coding});
    end
  endtask

  task automatic add_name(input logic [7:0] n);
    push({8'h84, n});
    for (int i = 0; i < n; i++) q.push_back(8'(i));
  endtask

  task automatic add_char(input logic [7:0] c);
    push({8'hA5, 8'h03, 8'h80, 8'h01, c & 8'h7D});
  endtask

  task automatic send();
    foreach (q[i]) begin
      send_valid <= 1'b1;
      send_last <= (i == q.size() - 1);
      send_data <= q[i];
      @(posedge clock);
    end
    send_valid <= 1'b0;
    send_last <= 1'b0;
    q.delete();
  endtask
endmodule // fcd_card

// ---- fcd_decoder.sv ----
`include "fcd_regs.svh"

// Notes on behaviour
// (RULE_01) Descriptor b8 reserved; b7 marks shareable.
// (RULE_02) Type field: working, internal, directory, reserved.
// (RULE_03) Structure field: none, transparent, linear, cyclic.
// (RULE_04) Data coding byte is neither checked nor used.
// (RULE_05) Record files carry two-byte record length.
// (RULE_06) Record files carry one-byte record count.
// (RULE_07) Name object holds one to sixteen bytes.
// (RULE_08) Proprietary template A5 holds nested sub-objects.
// (RULE_09) Private sub-objects follow defined ones, tag C0.
// (RULE_10) Same-tag sub-objects stay adjacent and ordered.
// (RULE_11) Sub-tags 80 to 83 name defined sub-objects.
// (RULE_12) Root directory always carries card characteristics.
// (RULE_13) Power sub-object only for application directories.
// (RULE_14) Minimum clock sub-object only for application directories.
// (RULE_15) Memory sub-object absent for elementary files.
// (RULE_16) Several power and clock sub-objects accepted.
// (RULE_17) Characteristics sub-object is 80, 01, one byte.
// (RULE_18) b1 set: stop either level, b3/b4 preference.
// (RULE_19) b1 clear: stop only at flagged level.
// (RULE_20) b1, b3, b4 all zero: never stop.
// (RULE_21) b5, b6, b7 flag voltage classes A, B, C.
// (RULE_22) Characteristics b8 and b2 must be zero.
// (RULE_23) Descriptor tag 82, length 02 or 05.
// (RULE_24) Skip unknown sub-objects; flag length overruns.
// (RULE_25) Reserved codes mark descriptor as unsupported.
module fcd_decoder (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Response byte stream.
  input wire logic start,
  input fcd_pkg::fcd_byte_t rx,
  // Selection context.
  input wire logic root_selected,
  // Descriptor results.
  output fcd_pkg::fcd_desc_t desc,
  output logic [15:0] record_length,
  output logic [7:0] record_count,
  output logic [4:0] name_length,
  // Card characteristics results.
  output fcd_pkg::fcd_clk_t clk_policy,
  output logic [2:0] class_support,
  output logic [3:0] power_count,
  output logic [3:0] minclk_count,
  // Status.
  output fcd_pkg::fcd_err_t err,
  output logic done
);
  import fcd_pkg::*;

  fcd_state_t state_r, state_nxt, step_nxt;
  logic [7:0] b;
  logic take;
  logic [7:0] tag_r, sub_tag_r, cnt_r, prop_rem_r, idx_r, desc_len_r;
  logic [3:0] seen_r;
  logic priv_r, name_seen_r, fin_r;
  logic sub_over, sub_defined, is_dir, is_elem, is_app, rec_file;

  assign b = rx.data;
  assign take = rx.valid;
  assign sub_over = (b > prop_rem_r - 8'h01);
  assign sub_defined = ((b & 8'hFC) == `FCD_SUB_CHAR);

  // ---------------------------------------------------------------------------
  // Parser sequencing
  // ---------------------------------------------------------------------------
  always_comb begin
    step_nxt = state_r;
    case (state_r)
      FCD_S_TAG: step_nxt = FCD_S_LEN;
      FCD_S_LEN: begin
        if (b == 8'h00) begin
          step_nxt = FCD_S_TAG;
        end else if (tag_r == `FCD_TAG_DESC) begin
          step_nxt = FCD_S_DESC;
        end else if (tag_r == `FCD_TAG_PROP) begin
          step_nxt = FCD_S_PTAG; // RULE_08
        end else begin
          step_nxt = FCD_S_SKIP;
        end
      end
      FCD_S_DESC, FCD_S_SKIP: begin
        if (cnt_r == 8'h01) begin
          step_nxt = FCD_S_TAG;
        end
      end
      FCD_S_PTAG: begin
        step_nxt = (prop_rem_r == 8'h01) ? FCD_S_TAG : FCD_S_PLEN; // RULE_24
      end
      FCD_S_PLEN: begin
        if (prop_rem_r == 8'h01) begin
          step_nxt = FCD_S_TAG;
        end else if (sub_over) begin
          step_nxt = FCD_S_SKIP; // RULE_24
        end else if (b == 8'h00) begin
          step_nxt = FCD_S_PTAG;
        end else begin
          step_nxt = FCD_S_PVAL;
        end
      end
      FCD_S_PVAL: begin
        if (cnt_r == 8'h01) begin
          step_nxt = (prop_rem_r == 8'h01) ? FCD_S_TAG : FCD_S_PTAG;
        end
      end
      default: step_nxt = FCD_S_TAG;
    endcase
    state_nxt = state_r;
    if (take) begin
      state_nxt = rx.last ? FCD_S_TAG : step_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      state_r <= FCD_S_TAG;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ---------------------------------------------------------------------------
  // Length counters
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      tag_r <= 8'h00;
      sub_tag_r <= 8'h00;
      cnt_r <= 8'h00;
      prop_rem_r <= 8'h00;
      idx_r <= 8'h00;
    end else if (take) begin
      case (state_r)
        FCD_S_TAG: tag_r <= b;
        FCD_S_LEN: begin
          cnt_r <= b;
          idx_r <= 8'h00;
          if (tag_r == `FCD_TAG_PROP) begin
            prop_rem_r <= b;
          end
        end
        FCD_S_DESC, FCD_S_SKIP: begin
          cnt_r <= cnt_r - 8'h01;
          idx_r <= idx_r + 8'h01;
        end
        FCD_S_PTAG: begin
          sub_tag_r <= b;
          prop_rem_r <= prop_rem_r - 8'h01;
        end
        FCD_S_PLEN: begin
          cnt_r <= sub_over ? prop_rem_r - 8'h01 : b;
          idx_r <= 8'h00;
          prop_rem_r <= prop_rem_r - 8'h01;
        end
        FCD_S_PVAL: begin
          cnt_r <= cnt_r - 8'h01;
          idx_r <= idx_r + 8'h01;
          prop_rem_r <= prop_rem_r - 8'h01;
        end
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Descriptor and name capture
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      desc <= '{valid: 1'b0, shareable: 1'b0, ftype: FCD_FT_RESERVED,
                fstruct: FCD_ST_NONE, unsupported: 1'b0};
      record_length <= 16'h0000;
      record_count <= 8'h00;
      desc_len_r <= 8'h00;
      name_length <= 5'h00;
      name_seen_r <= 1'b0;
    end else if (take) begin
      if (state_r == FCD_S_LEN && tag_r == `FCD_TAG_DESC) begin
        desc_len_r <= b; // RULE_23
      end
      if (state_r == FCD_S_LEN && tag_r == `FCD_TAG_NAME) begin
        name_seen_r <= 1'b1;
        name_length <= (b > `FCD_NAME_MAX) ? 5'h00 : b[4:0]; // RULE_07
      end
      if (state_r == FCD_S_DESC) begin
        case (idx_r)
          8'h00: begin
            desc.valid <= 1'b1;
            desc.shareable <= b[`FCD_FD_SHARE_BIT] & // RULE_01
              ~b[`FCD_FD_RSV_BIT];
            case (b[`FCD_FD_TYPE_HI:`FCD_FD_TYPE_LO]) // RULE_02
              `FCD_TYPE_WORKING: desc.ftype <= FCD_FT_WORKING;
              `FCD_TYPE_INTERNAL: desc.ftype <= FCD_FT_INTERNAL;
              `FCD_TYPE_DIR: desc.ftype <= FCD_FT_DIRECTORY;
              default: desc.ftype <= FCD_FT_RESERVED;
            endcase
            case (b[`FCD_FD_STRUCT_HI:`FCD_FD_STRUCT_LO]) // RULE_03
              `FCD_STRUCT_NONE: desc.fstruct <= FCD_ST_NONE;
              `FCD_STRUCT_TRANSP: desc.fstruct <= FCD_ST_TRANSPARENT;
              `FCD_STRUCT_LINEAR: desc.fstruct <= FCD_ST_LINEAR;
              `FCD_STRUCT_CYCLIC: desc.fstruct <= FCD_ST_CYCLIC;
              default: desc.fstruct <= FCD_ST_RESERVED;
            endcase
            desc.unsupported <= b[`FCD_FD_RSV_BIT] // RULE_25
              | (b[5:3] == 3'h2) | (b[5:3] == 3'h3) | (b[5:3] == 3'h4)
              | (b[5:3] == 3'h5) | (b[5:3] == 3'h6)
              | (b[2:0] == 3'h3) | (b[2:0] == 3'h4) | (b[2:0] == 3'h5)
              | (b[2:0] == 3'h7);
          end
          // Index one is the data coding byte and is ignored. RULE_04
          8'h02: record_length[15:8] <= b; // RULE_05
          8'h03: record_length[7:0] <= b;
          8'h04: record_count <= b; // RULE_06
          default: record_count <= record_count;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Proprietary sub-objects
  // ---------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      seen_r <= 4'h0;
      priv_r <= 1'b0;
      power_count <= 4'h0;
      minclk_count <= 4'h0;
      clk_policy <= '0;
      class_support <= 3'h0;
    end else if (take) begin
      if (state_r == FCD_S_PTAG && prop_rem_r != 8'h01) begin
        if (sub_defined) begin
          seen_r[b[1:0]] <= 1'b1; // RULE_11
        end
        if ((b & `FCD_PRIVATE_MASK) == `FCD_PRIVATE_MASK) begin
          priv_r <= 1'b1; // RULE_09
        end
        if (b == `FCD_SUB_POWER && power_count != 4'hF) begin
          power_count <= power_count + 4'h1; // RULE_16
        end
        if (b == `FCD_SUB_MINCLK && minclk_count != 4'hF) begin
          minclk_count <= minclk_count + 4'h1; // RULE_16
        end
      end
      if (state_r == FCD_S_PVAL && sub_tag_r == `FCD_SUB_CHAR &&
          idx_r == 8'h00) begin
        clk_policy.stop_allowed <= b[`FCD_CH_STOP_BIT]; // RULE_18
        clk_policy.stop_high_ok <= b[`FCD_CH_STOP_BIT] | // RULE_19
          (b[`FCD_CH_HIGH_BIT] & ~b[`FCD_CH_LOW_BIT]);
        clk_policy.stop_low_ok <= b[`FCD_CH_STOP_BIT] | // RULE_20
          (b[`FCD_CH_LOW_BIT] & ~b[`FCD_CH_HIGH_BIT]);
        clk_policy.pref_high <= b[`FCD_CH_STOP_BIT] &
          b[`FCD_CH_HIGH_BIT] & ~b[`FCD_CH_LOW_BIT];
        clk_policy.pref_low <= b[`FCD_CH_STOP_BIT] &
          b[`FCD_CH_LOW_BIT] & ~b[`FCD_CH_HIGH_BIT];
        class_support <= b[`FCD_CH_CLASS_HI:`FCD_CH_CLASS_LO]; // RULE_21
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Error flags and completion
  // ---------------------------------------------------------------------------
  assign is_dir = (desc.ftype == FCD_FT_DIRECTORY);
  assign is_elem = desc.valid & ~is_dir;
  assign is_app = is_dir & name_seen_r & ~root_selected;
  assign rec_file = (desc.fstruct == FCD_ST_LINEAR) ||
                    (desc.fstruct == FCD_ST_CYCLIC);

  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      err <= '0;
      fin_r <= 1'b0;
      done <= 1'b0;
    end else begin
      fin_r <= take & rx.last;
      done <= fin_r;
      if (take && state_r == FCD_S_LEN) begin
        if (tag_r == `FCD_TAG_DESC && b != `FCD_DESC_LEN_SHORT &&
            b != `FCD_DESC_LEN_LONG) begin
          err.desc_length <= 1'b1; // RULE_23
        end
        if (tag_r == `FCD_TAG_NAME && (b == 8'h00 || b > `FCD_NAME_MAX)) begin
          err.name_length <= 1'b1; // RULE_07
        end
      end
      if (take && state_r == FCD_S_PTAG) begin
        if (prop_rem_r == 8'h01) begin
          err.overrun <= 1'b1; // RULE_24
        end
        if (sub_defined && seen_r[b[1:0]] && sub_tag_r != b) begin
          err.grouping <= 1'b1; // RULE_10
        end
        if (sub_defined && priv_r) begin
          err.private_order <= 1'b1; // RULE_09
        end
      end
      if (take && state_r == FCD_S_PLEN) begin
        // A zero-length sub-object may legally close the template.
        if (sub_over) begin
          err.overrun <= 1'b1; // RULE_24
        end
        if (sub_tag_r == `FCD_SUB_CHAR && b != `FCD_CHAR_LEN) begin
          err.char_length <= 1'b1; // RULE_17
        end
      end
      if (take && state_r == FCD_S_PVAL && sub_tag_r == `FCD_SUB_CHAR &&
          idx_r == 8'h00 && (b[`FCD_CH_RSV_HI_BIT] | b[`FCD_CH_RSV_LO_BIT] |
          (b[`FCD_CH_HIGH_BIT] & b[`FCD_CH_LOW_BIT]))) begin
        err.char_reserved <= 1'b1; // RULE_22
      end
      if (take && rx.last && step_nxt != FCD_S_TAG) begin
        err.truncated <= 1'b1;
      end
      if (fin_r) begin
        if (rec_file && desc_len_r != `FCD_DESC_LEN_LONG) begin
          err.record_missing <= 1'b1; // RULE_05 RULE_06
        end
        err.presence <= err.presence
          | (root_selected & ~seen_r[0]) // RULE_12
          | (seen_r[1] & ~is_app) // RULE_13
          | (seen_r[2] & ~is_app) // RULE_14
          | (seen_r[3] & is_elem); // RULE_15
      end
    end
  end

endmodule // fcd_decoder

// ---- fcd_decoder_bench.sv ----
module fcd_decoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcd_pkg::*;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic start = 1'b0;
  logic root_selected = 1'b0;
  fcd_byte_t rx;
  fcd_desc_t desc;
  logic [15:0] record_length;
  logic [7:0] record_count;
  logic [4:0] name_length;
  fcd_clk_t clk_policy;
  logic [2:0] class_support;
  logic [3:0] power_count;
  logic [3:0] minclk_count;
  fcd_err_t err;
  logic done;
  int err_total = 0;
  int checks_done = 0;

  always #4 clock = ~clock;

  fcd_card fcd_card_i (.clock(clock), .rx(rx));
  fcd_decoder fcd_decoder_i (.clock(clock), .rstn(rstn), .start(start),
    .rx(rx), .root_selected(root_selected), .desc(desc),
    .record_length(record_length), .record_count(record_count),
    .name_length(name_length), .clk_policy(clk_policy),
    .class_support(class_support), .power_count(power_count),
    .minclk_count(minclk_count), .err(err), .done(done));

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic run(input logic root);
    int n;
    @(posedge clock);
    start <= 1'b1;
    root_selected <= root;
    @(posedge clock);
    start <= 1'b0;
    fcd_card_i.send();
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (done !== 1'b1 && n < 8);
    chk("done", 16'h0001, 16'(done));
  endtask

  task automatic t_desc();
    logic [7:0] fds [8];
    logic [7:0] fd;
    fcd_ftype_t ft;
    fcd_fstruct_t st;
    fds = '{8'h41, 8'h0A, 8'h46, 8'h38, 8'h21, 8'h03, 8'h81, 8'h17};
    foreach (fds[i]) begin
      fd = fds[i];
      case (fd[5:3])
        3'h0: ft = FCD_FT_WORKING;
        3'h1: ft = FCD_FT_INTERNAL;
        3'h7: ft = FCD_FT_DIRECTORY;
        default: ft = FCD_FT_RESERVED;
      endcase
      case (fd[2:0])
        3'h0: st = FCD_ST_NONE;
        3'h1: st = FCD_ST_TRANSPARENT;
        3'h2: st = FCD_ST_LINEAR;
        3'h6: st = FCD_ST_CYCLIC;
        default: st = FCD_ST_RESERVED;
      endcase
      fcd_card_i.add_desc(fd, ~fd);
      run(1'b0);
      chk("unsupported", 16'(fd[7] | ft == FCD_FT_RESERVED |
        st == FCD_ST_RESERVED), 16'(desc.unsupported));
      chk("valid", 16'h0001, 16'(desc.valid));
      if (!fd[7]) begin
        chk("shareable", 16'(fd[6]), 16'(desc.shareable));
        chk("ftype", 16'(ft), 16'(desc.ftype));
        chk("fstruct", 16'(st), 16'(desc.fstruct));
      end
      if (st == FCD_ST_LINEAR || st == FCD_ST_CYCLIC) begin
        chk("rec_len", 16'h001C, record_length);
        chk("rec_cnt", 16'h0007, 16'(record_count));
      end
    end
    $display("t_desc finished");
  endtask

  task automatic t_char();
    logic [7:0] cbs [8];
    logic [7:0] c;
    fcd_clk_t e;
    cbs = '{8'h01, 8'h05, 8'h09, 8'h04, 8'h08, 8'h00, 8'h71, 8'h60};
    foreach (cbs[i]) begin
      c = cbs[i];
      e = {c[0], c[0] | c[2], c[0] | c[3], c[0] & c[2], c[0] & c[3]};
      fcd_card_i.add_desc(8'h38, 8'h21);
      fcd_card_i.add_char(c);
      run(1'b1);
      chk("stop", 16'(e[4:2]),
        16'(clk_policy[4:2]));
      if (c[0]) chk("pref", 16'(e[1:0]), 16'(clk_policy[1:0]));
      chk("class", 16'(c[6:4]), 16'(class_support));
      chk("err", 16'h0000, 16'(err));
    end
    $display("t_char finished");
  endtask

  task automatic t_app();
    fcd_card_i.add_desc(8'h38, 8'h21);
    fcd_card_i.add_name(8'h10);
    fcd_card_i.push({8'hA5, 8'h17, 8'h81, 8'h03, 8'h01, 8'h10, 8'h0A,
      8'h81, 8'h03, 8'h02, 8'h20, 8'hFF, 8'h82, 8'h01, 8'h0A, 8'h82,
      8'h01, 8'h14, 8'h83, 8'h02, 8'h10, 8'h00, 8'hC1, 8'h01, 8'h00});
    run(1'b0);
    chk("name_len", 16'h0010, 16'(name_length));
    chk("power_cnt", 16'h0002, 16'(power_count));
    chk("minclk_cnt", 16'h0002, 16'(minclk_count));
    chk("err", 16'h0000, 16'(err));
    $display("t_app finished");
  endtask

  task automatic raw_case(input logic root, input logic [9:0] bits,
                          input logic [7:0] b[$]);
    fcd_card_i.push(b);
    run(root);
    chk("err_bit", 16'(bits), 16'(err & bits));
  endtask

  task automatic err_case(input logic root, input logic [7:0] fd,
                          input logic [9:0] bits, input logic [7:0] b[$]);
    fcd_card_i.add_desc(fd, 8'h21);
    raw_case(root, bits, b);
  endtask

  task automatic t_err();
    err_case(1'b1, 8'h38, 10'h001, {8'h8A, 8'h01, 8'h05});
    err_case(1'b0, 8'h41, 10'h001,
      {8'hA5, 8'h05, 8'h81, 8'h03, 8'h01, 8'h10, 8'h0A});
    err_case(1'b0, 8'h38, 10'h001,
      {8'hA5, 8'h03, 8'h82, 8'h01, 8'h0A});
    err_case(1'b0, 8'h41, 10'h001,
      {8'hA5, 8'h04, 8'h83, 8'h02, 8'h00, 8'h10});
    err_case(1'b1, 8'h38, 10'h002,
      {8'hA5, 8'h03, 8'h80, 8'h01, 8'h83});
    err_case(1'b1, 8'h38, 10'h004,
      {8'hA5, 8'h04, 8'h80, 8'h02, 8'h01, 8'h00});
    err_case(1'b1, 8'h38, 10'h040,
      {8'hA5, 8'h03, 8'h80, 8'h05, 8'h01});
    err_case(1'b0, 8'h38, 10'h080, {8'h84, 8'h00});
    err_case(1'b1, 8'h38, 10'h008, {8'hA5, 8'h06, 8'hC1, 8'h01, 8'h00,
      8'h80, 8'h01, 8'h01});
    err_case(1'b0, 8'h38, 10'h010, {8'h84, 8'h01, 8'hA0, 8'hA5, 8'h0D,
      8'h81, 8'h03, 8'h01, 8'h10, 8'h0A, 8'h82, 8'h01, 8'h0A, 8'h81,
      8'h03, 8'h01, 8'h10, 8'h0A});
    raw_case(1'b0, 10'h200, {8'h82, 8'h03, 8'h41, 8'h21, 8'h00});
    raw_case(1'b0, 10'h100, {8'h82, 8'h02, 8'h42, 8'h21});
    raw_case(1'b0, 10'h020, {8'h82, 8'h02, 8'h41});
    $display("t_err finished");
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clock);
    err_total++;
    results();
  end

  initial begin
    repeat (20) @(posedge clock);
    rstn <= 1'b1;
    t_desc();
    t_char();
    t_app();
    t_err();
    results();
  end
endmodule // fcd_decoder_bench

// ---- fcd_decoder_chk.sv ----
module fcd_decoder_chk (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Inputs watched.
  input wire logic start,
  input fcd_pkg::fcd_byte_t rx,
  // Outputs watched.
  input fcd_pkg::fcd_desc_t desc,
  input wire logic [15:0] record_length,
  input wire logic [7:0] record_count,
  input fcd_pkg::fcd_clk_t clk_policy,
  input wire logic done
);
  import fcd_pkg::*;
  logic take;
  logic [3:0] cnt_r;
  logic [7:0] b0_r;
  logic [7:0] b1_r;
  logic [7:0] prev_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  assign take = rstn && !start && rx.valid;

  // ----
  // Byte position since the last start.
  // ----
  always_ff @(posedge clock) begin
    if (!rstn || start) begin
      cnt_r <= 4'h0;
    end else if (take && cnt_r != 4'hF) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (take) begin
      prev_r <= rx.data;
      if (cnt_r == 4'h0) b0_r <= rx.data;
      if (cnt_r == 4'h1) b1_r <= rx.data;
    end
  end

  sequence s_fd;
    take && cnt_r == 4'h2 && b0_r == 8'h82 && !rx.data[7];
  endsequence
  sequence s_len5;
    take && b0_r == 8'h82 && b1_r == 8'h05;
  endsequence
  sequence s_pulse;
    !done ##1 done ##1 !done;
  endsequence

  AST_FD_SHARE: assert property (s_fd |=>
    desc.shareable == $past(rx.data[6])) else $error("shareable flag wrong");
  AST_FD_RSV: assert property (take && cnt_r == 4'h2 &&
    b0_r == 8'h82 && rx.data[7] |=> desc.unsupported)
    else $error("reserved byte accepted");
  AST_FD_TYPE: assert property (s_fd ##0 rx.data[5:3] == 3'h7
    |=> desc.ftype == FCD_FT_DIRECTORY) else $error("directory type wrong");
  AST_FD_STRUCT: assert property (s_fd ##0 rx.data[2:0] == 3'h6
    |=> desc.fstruct == FCD_ST_CYCLIC) else $error("cyclic structure wrong");
  AST_REC_LEN: assert property (s_len5 ##0 cnt_r == 4'h5
    |=> record_length == {$past(prev_r), $past(rx.data)})
    else $error("record length wrong");
  AST_REC_CNT: assert property (s_len5 ##0 cnt_r == 4'h6
    |=> record_count == $past(rx.data)) else $error("record count wrong");
  AST_DONE: assert property (take && rx.last |=> s_pulse)
    else $error("done pulse misplaced");
  AST_STOP_BOTH: assert property (done &&
    clk_policy.stop_allowed |-> clk_policy.stop_high_ok &&
    clk_policy.stop_low_ok) else $error("free stop must allow both levels");
endmodule // fcd_decoder_chk

bind fcd_decoder fcd_decoder_chk fcd_decoder_chk_i (
  .clock(clock),
  .rstn(rstn),
  .start(start),
  .rx(rx),
  .desc(desc),
  .record_length(record_length),
  .record_count(record_count),
  .clk_policy(clk_policy),
  .done(done)
);

// ---- fcd_pkg.sv ----
package fcd_pkg;

  typedef enum logic [1:0] {
    FCD_FT_WORKING,
    FCD_FT_INTERNAL,
    FCD_FT_DIRECTORY,
    FCD_FT_RESERVED
  } fcd_ftype_t;

  typedef enum logic [2:0] {
    FCD_ST_NONE,
    FCD_ST_TRANSPARENT,
    FCD_ST_LINEAR,
    FCD_ST_CYCLIC,
    FCD_ST_RESERVED
  } fcd_fstruct_t;

  typedef enum logic [2:0] {
    FCD_S_TAG,
    FCD_S_LEN,
    FCD_S_DESC,
    FCD_S_SKIP,
    FCD_S_PTAG,
    FCD_S_PLEN,
    FCD_S_PVAL
  } fcd_state_t;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } fcd_byte_t;

  typedef struct packed {
    logic valid;
    logic shareable;
    fcd_ftype_t ftype;
    fcd_fstruct_t fstruct;
    logic unsupported;
  } fcd_desc_t;

  typedef struct packed {
    logic stop_allowed;
    logic stop_high_ok;
    logic stop_low_ok;
    logic pref_high;
    logic pref_low;
  } fcd_clk_t;

  typedef struct packed {
    logic desc_length;
    logic record_missing;
    logic name_length;
    logic overrun;
    logic truncated;
    logic grouping;
    logic private_order;
    logic char_length;
    logic char_reserved;
    logic presence;
  } fcd_err_t;

endpackage

// ---- fcd_regs.svh ----
`ifndef FCD_REGS_SVH
`define FCD_REGS_SVH

// ---------------------------------------------------------------------------
// Object tags
// ---------------------------------------------------------------------------
`define FCD_TAG_DESC 8'h82
`define FCD_TAG_NAME 8'h84
`define FCD_TAG_PROP 8'hA5
`define FCD_SUB_CHAR 8'h80
`define FCD_SUB_POWER 8'h81
`define FCD_SUB_MINCLK 8'h82
`define FCD_SUB_MEMORY 8'h83
`define FCD_PRIVATE_MASK 8'hC0

// ---------------------------------------------------------------------------
// Lengths
// ---------------------------------------------------------------------------
`define FCD_DESC_LEN_SHORT 8'h02
`define FCD_DESC_LEN_LONG 8'h05
`define FCD_CHAR_LEN 8'h01
`define FCD_NAME_MAX 8'h10

// ---------------------------------------------------------------------------
// Descriptor byte fields and codes
// ---------------------------------------------------------------------------
`define FCD_FD_RSV_BIT 7
`define FCD_FD_SHARE_BIT 6
`define FCD_FD_TYPE_HI 5
`define FCD_FD_TYPE_LO 3
`define FCD_FD_STRUCT_HI 2
`define FCD_FD_STRUCT_LO 0
`define FCD_TYPE_WORKING 3'h0
`define FCD_TYPE_INTERNAL 3'h1
`define FCD_TYPE_DIR 3'h7
`define FCD_STRUCT_NONE 3'h0
`define FCD_STRUCT_TRANSP 3'h1
`define FCD_STRUCT_LINEAR 3'h2
`define FCD_STRUCT_CYCLIC 3'h6

// ---------------------------------------------------------------------------
// Characteristics byte fields
// ---------------------------------------------------------------------------
`define FCD_CH_STOP_BIT 0
`define FCD_CH_RSV_LO_BIT 1
`define FCD_CH_HIGH_BIT 2
`define FCD_CH_LOW_BIT 3
`define FCD_CH_CLASS_LO 4
`define FCD_CH_CLASS_HI 6
`define FCD_CH_RSV_HI_BIT 7

`endif
